/* File: smbt_map.svh */
`ifndef SMBT_MAP_SVH
`define SMBT_MAP_SVH

// ==================================================================
// Register map of the serial target.
// ==================================================================
// Control register holding the alert filter and the timeout enable.
`define SMBT_CTRL_ADDR      8'h22
`define SMBT_CTRL_RESET     8'h01
`define SMBT_TOUT_EN_BIT    7
// Pointer value after power-up; reset loads the pointer with 00h.
`define SMBT_PTR_RESET      8'h00

// ==================================================================
// Target addresses.
// ==================================================================
`define SMBT_ARA_ADDR       7'h0C
`define SMBT_ADDR_LL        7'h18
`define SMBT_ADDR_LF        7'h19
`define SMBT_ADDR_LH        7'h1A
`define SMBT_ADDR_FL        7'h29
`define SMBT_ADDR_FF        7'h2A
`define SMBT_ADDR_FH        7'h2B
`define SMBT_ADDR_HL        7'h4C
`define SMBT_ADDR_HF        7'h4D
`define SMBT_ADDR_HH        7'h4E

// ==================================================================
// Timing.
// ==================================================================
// Bus inactivity timeout in milliseconds and the core clock in kHz.
`define SMBT_TIMEOUT_MS     25
`define SMBT_CLK_KHZ        100000
// Cycles the strap synchronisers settle before capture.
`define SMBT_STRAP_SETTLE   2'h3

`endif

/* File: smbt_pkg.sv */
// ==================================================================
// Types shared by the serial target modules.
// ==================================================================
package smbt_pkg;

  // Sensed level of a three-state address strap.
  typedef enum logic [1:0] {
    SMBT_STRAP_LOW   = 2'h0,
    SMBT_STRAP_FLOAT = 2'h1,
    SMBT_STRAP_HIGH  = 2'h2
  } smbt_strap_t;

  // Serial engine states, one-hot.
  typedef enum logic [6:0] {
    SMBT_ST_IDLE  = 7'b000_0001,
    SMBT_ST_ADDR  = 7'b000_0010,
    SMBT_ST_AACK  = 7'b000_0100,
    SMBT_ST_WBYTE = 7'b000_1000,
    SMBT_ST_WACK  = 7'b001_0000,
    SMBT_ST_RBYTE = 7'b010_0000,
    SMBT_ST_RACK  = 7'b100_0000
  } smbt_state_t;

  // One register write handed to the register file.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } smbt_reg_wr_t;

endpackage

/* File: smbt_sync.sv */
`timescale 1ns/100ps

// ==================================================================
// Two-stage synchroniser for inputs from outside the clock domain.
// ==================================================================
module smbt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= '1;
      q        <= '1;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // smbt_sync

/* File: smbt_strap_decode.sv */
`timescale 1ns/100ps
`include "smbt_map.svh"

// ==================================================================
// Address strap capture and decode.
// ==================================================================
module smbt_strap_decode (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire smbt_pkg::smbt_strap_t strap_a,
  input  wire smbt_pkg::smbt_strap_t strap_b,
  output logic [6:0]               own_addr,
  output logic                     addr_valid
);
  import smbt_pkg::*;

  logic [1:0] settle_reg;
  logic [1:0] row;
  logic [1:0] col;
  logic [3:0] idx;
  logic [6:0] addr_sel;

  // Rows follow strap A, columns strap B.
  assign row = (strap_a == SMBT_STRAP_LOW)   ? 2'h0 :
               (strap_a == SMBT_STRAP_FLOAT) ? 2'h1 : 2'h2;
  assign col = (strap_b == SMBT_STRAP_LOW)   ? 2'h0 :
               (strap_b == SMBT_STRAP_FLOAT) ? 2'h1 : 2'h2;
  assign idx = 4'({2'h0, row} * 4'h3 + {2'h0, col});

  // Nine addresses selected by the two three-state straps.
  assign addr_sel = (idx == 4'h0) ? `SMBT_ADDR_LL :  // RULE3
                    (idx == 4'h1) ? `SMBT_ADDR_LF :
                    (idx == 4'h2) ? `SMBT_ADDR_LH :
                    (idx == 4'h3) ? `SMBT_ADDR_FL :
                    (idx == 4'h4) ? `SMBT_ADDR_FF :
                    (idx == 4'h5) ? `SMBT_ADDR_FH :
                    (idx == 4'h6) ? `SMBT_ADDR_HL :
                    (idx == 4'h7) ? `SMBT_ADDR_HF : `SMBT_ADDR_HH;

  // Capture once after the synchronisers settle, then hold until reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      settle_reg <= 2'h0;
      addr_valid <= 1'b0;
      own_addr   <= 7'h00;
    end else if (!addr_valid) begin
      settle_reg <= 2'(settle_reg + 2'h1);
      if (settle_reg == `SMBT_STRAP_SETTLE) begin
        addr_valid <= 1'b1;      // RULE4
        own_addr   <= addr_sel;  // RULE4
      end
    end
  end

endmodule // smbt_strap_decode

/* File: smbt_target.sv */
// Contract
// RULE1: With timeout enabled, abandon the transfer after 25 ms of bus silence.
// RULE2: Timeout is disabled after power-up until software enables it.
// RULE3: Decode two three-state straps into one of nine target addresses.
// RULE4: Straps are captured once at power-up; later changes are ignored.
// RULE5: After start, shift in seven address bits and direction, MSB first.
// RULE6: On match, pull data low for the acknowledge slot.
// RULE7: Direction 0 is a master write, 1 is a master read.
// RULE8: Master starts with data falling while clock is high.
// RULE9: Nine clocks per byte; data rising while clock high is a stop.
// RULE10: Master ends a read with no acknowledge followed by a stop.
// RULE11: One transfer is only read or only write; new start to switch.
// RULE12: Accept one or two written bytes; return one byte per read.
// RULE13: First written byte always loads the register pointer.
// RULE14: Second written byte goes into the register the pointer selects.
// RULE15: A read returns the register selected by the current pointer.
// RULE16: Separate read and write locations are chosen through the pointer.
// RULE17: In alert mode, pull alert low on limit or open sensor condition.
// RULE18: Alert output is open drain: pull low or release only.
// RULE19: While alerting, answer the query address with own address and 1.
// RULE20: Several responders are resolved by ordinary bus arbitration.
// RULE21: Release alert after the query only if the cause is gone.
// RULE22: Master repeats queries while the shared alert line stays low.
// RULE23: Control register top bit is the timeout enable, zero after reset.
// RULE24: Alert release also needs the latched status flags cleared.
// RULE25: On timeout, release data and return to idle awaiting start.
// RULE26: Non-matching transfers get no acknowledge and data stays released.
`timescale 1ns/100ps
`include "smbt_map.svh"

// ==================================================================
// Serial target with query-address alert handshake.
// ==================================================================
module smbt_target #(
  parameter int unsigned TIMEOUT_CYCLES = `SMBT_TIMEOUT_MS * `SMBT_CLK_KHZ
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  scl_pin,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire smbt_pkg::smbt_strap_t addr_strap_a,
  input  wire smbt_pkg::smbt_strap_t addr_strap_b,
  input  wire logic                  alert_mode,
  input  wire logic                  alert_cond,
  input  wire logic                  status_latched,
  output logic                       alert_out,
  output logic                       alert_oe,
  input  wire logic [7:0]            reg_rdata,
  output logic [7:0]                 reg_ptr,
  output logic                       reg_wr_stb,
  output smbt_pkg::smbt_reg_wr_t     reg_wr,
  output logic [7:0]                 alert_ctrl,
  output logic [6:0]                 own_addr
);
  import smbt_pkg::*;

  // ================================================================
  // Pin synchronisers and strap decode.
  // ================================================================
  logic [5:0] pins_q;
  logic       scl_s;
  logic       sda_s;
  logic       addr_valid;

  // Clock, data and straps all arrive from outside the clock domain.
  smbt_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .d     ({scl_pin, sda_in, addr_strap_a, addr_strap_b}),
    .q     (pins_q)
  );

  assign scl_s = pins_q[5];
  assign sda_s = pins_q[4];

  smbt_strap_decode u_strap (
    .clk        (clk),
    .reset      (reset),
    .strap_a    (smbt_strap_t'(pins_q[3:2])),
    .strap_b    (smbt_strap_t'(pins_q[1:0])),
    .own_addr   (own_addr),
    .addr_valid (addr_valid)
  );

  // ================================================================
  // Bus event detection.
  // ================================================================
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic bus_edge;

  // Previous synchronised levels, used for edge detection.
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // Start and stop are data edges while the clock stays high.
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;  // RULE8
  assign stop_det  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;  // RULE9
  assign bus_edge  = (scl_s ^ scl_d_reg) | (sda_s ^ sda_d_reg);

  // ================================================================
  // Registers of the serial engine.
  // ================================================================
  smbt_state_t  state_reg,  state_next;
  logic [3:0]   cnt_reg,    cnt_next;
  logic [7:0]   shift_reg,  shift_next;
  logic [7:0]   tx_reg,     tx_next;
  logic         rw_reg,     rw_next;
  logic         ara_reg,    ara_next;
  logic [1:0]   widx_reg,   widx_next;
  logic [7:0]   ptr_reg,    ptr_next;
  logic [7:0]   ctrl_reg,   ctrl_next;
  logic         drive_reg,  drive_next;
  logic         stb_next;
  smbt_reg_wr_t wr_next;
  logic         ara_done;
  logic         alert_reg;
  logic [31:0]  tout_cnt_reg;
  logic         tout_hit;
  logic         own_hit;
  logic         ara_hit;
  logic [7:0]   rd_byte;
  logic [7:0]   load_byte;
  logic [7:0]   shift_in;

  // Address compare on the byte just shifted in.
  assign own_hit  = addr_valid && (shift_reg[7:1] == own_addr);      // RULE5
  assign ara_hit  = (shift_reg[7:1] == `SMBT_ARA_ADDR) && shift_reg[0]
                    && alert_reg;                                     // RULE19
  assign shift_in = {shift_reg[6:0], sda_s};

  // The control register is held here; all others live outside.
  assign rd_byte   = (ptr_reg == `SMBT_CTRL_ADDR) ? ctrl_reg : reg_rdata;  // RULE15
  assign load_byte = ara_reg ? {own_addr, 1'b1} : rd_byte;                 // RULE19

  // Inactivity timeout only counts while a transfer is open.
  assign tout_hit = ctrl_reg[`SMBT_TOUT_EN_BIT]
                    && (tout_cnt_reg >= TIMEOUT_CYCLES - 1);  // RULE1

  // ================================================================
  // Next-state logic of the serial engine.
  // ================================================================
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    tx_next    = tx_reg;
    rw_next    = rw_reg;
    ara_next   = ara_reg;
    widx_next  = widx_reg;
    ptr_next   = ptr_reg;
    ctrl_next  = ctrl_reg;
    drive_next = drive_reg;
    stb_next   = 1'b0;
    wr_next    = reg_wr;
    ara_done   = 1'b0;
    if (tout_hit) begin
      state_next = SMBT_ST_IDLE;  // RULE25
      drive_next = 1'b0;          // RULE25
    end else if (start_det) begin
      state_next = SMBT_ST_ADDR;  // RULE11
      cnt_next   = 4'h0;
      drive_next = 1'b0;
    end else if (stop_det) begin
      state_next = SMBT_ST_IDLE;  // RULE9
      drive_next = 1'b0;
    end else begin
      case (state_reg)
        SMBT_ST_ADDR: begin
          if (scl_rise) begin
            shift_next = shift_in;              // RULE5
            cnt_next   = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == 4'h8) begin
            if (own_hit || ara_hit) begin
              state_next = SMBT_ST_AACK;
              drive_next = 1'b1;                // RULE6
              rw_next    = shift_reg[0];        // RULE7
              ara_next   = ~own_hit;
            end else begin
              state_next = SMBT_ST_IDLE;        // RULE26
            end
          end
        end
        SMBT_ST_AACK: begin
          if (scl_fall) begin
            cnt_next = 4'h0;
            if (rw_reg) begin
              state_next = SMBT_ST_RBYTE;       // RULE7
              tx_next    = load_byte;
              drive_next = ~load_byte[7];
            end else begin
              state_next = SMBT_ST_WBYTE;
              widx_next  = 2'h0;
              drive_next = 1'b0;
            end
          end
        end
        SMBT_ST_RBYTE: begin
          // Released bit seen low means another responder won.
          if (scl_rise && !drive_reg && !sda_s) begin
            state_next = SMBT_ST_IDLE;          // RULE20
          end else if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              state_next = SMBT_ST_RACK;
              drive_next = 1'b0;
            end else begin
              tx_next    = {tx_reg[6:0], 1'b0};
              cnt_next   = 4'(cnt_reg + 4'h1);
              drive_next = ~tx_reg[6];
            end
          end
        end
        SMBT_ST_RACK: begin
          // Only one byte per read, whatever the master answers.
          if (scl_fall) begin
            state_next = SMBT_ST_IDLE;          // RULE12
            ara_done   = ara_reg;               // RULE21
          end
        end
        SMBT_ST_WBYTE: begin
          if (scl_rise) begin
            shift_next = shift_in;
            cnt_next   = 4'(cnt_reg + 4'h1);
          end else if (scl_fall && cnt_reg == 4'h8) begin
            if (widx_reg == 2'h0) begin
              ptr_next = shift_reg;             // RULE13
            end else if (widx_reg == 2'h1) begin
              if (ptr_reg == `SMBT_CTRL_ADDR) begin
                ctrl_next = shift_reg;          // RULE14
              end else begin
                stb_next     = 1'b1;            // RULE14
                wr_next.addr = ptr_reg;         // RULE16
                wr_next.data = shift_reg;
              end
            end
            if (widx_reg == 2'h2) begin
              state_next = SMBT_ST_IDLE;        // RULE12
            end else begin
              state_next = SMBT_ST_WACK;
              drive_next = 1'b1;
            end
          end
        end
        SMBT_ST_WACK: begin
          if (scl_fall) begin
            state_next = SMBT_ST_WBYTE;
            cnt_next   = 4'h0;
            drive_next = 1'b0;
            widx_next  = 2'(widx_reg + 2'h1);
          end
        end
        default: begin
          state_next = SMBT_ST_IDLE;
          drive_next = 1'b0;
        end
      endcase
    end
  end

  // ================================================================
  // Engine state registers.
  // ================================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= SMBT_ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg    <= 8'h00;
      rw_reg    <= 1'b0;
      ara_reg   <= 1'b0;
      widx_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      tx_reg    <= tx_next;
      rw_reg    <= rw_next;
      ara_reg   <= ara_next;
      widx_reg  <= widx_next;
    end
  end

  // Pointer, control register and the write port toward the register file.
  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_reg    <= `SMBT_PTR_RESET;
      ctrl_reg   <= `SMBT_CTRL_RESET;  // RULE2 RULE23
      drive_reg  <= 1'b0;
      reg_wr_stb <= 1'b0;
      reg_wr     <= '0;
    end else begin
      ptr_reg    <= ptr_next;
      ctrl_reg   <= ctrl_next;
      drive_reg  <= drive_next;
      reg_wr_stb <= stb_next;
      reg_wr     <= wr_next;
    end
  end

  // ================================================================
  // Bus inactivity timer.
  // ================================================================
  // Any edge on either line restarts the count; idle keeps it cleared.
  always_ff @(posedge clk) begin
    if (reset || state_reg == SMBT_ST_IDLE || bus_edge || tout_hit) begin
      tout_cnt_reg <= 32'h0000_0000;
    end else if (tout_cnt_reg < TIMEOUT_CYCLES) begin
      tout_cnt_reg <= tout_cnt_reg + 32'h0000_0001;  // RULE1
    end
  end

  // ================================================================
  // Alert latch.
  // ================================================================
  // A new cause wins over a release in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      alert_reg <= 1'b0;
    end else if (!alert_mode) begin
      alert_reg <= 1'b0;
    end else if (alert_cond) begin
      alert_reg <= 1'b1;                          // RULE17
    end else if (ara_done && !status_latched) begin
      alert_reg <= 1'b0;                          // RULE21 RULE24
    end
  end

  // ================================================================
  // Open-drain outputs.
  // ================================================================
  // Both pins are only ever pulled low; the pull-up supplies the high.
  assign sda_out    = 1'b0;
  assign sda_oe     = drive_reg;
  assign alert_out  = 1'b0;       // RULE18
  assign alert_oe   = alert_reg;  // RULE18
  assign reg_ptr    = ptr_reg;
  assign alert_ctrl = ctrl_reg;

endmodule // smbt_target

/* File: smbt_host_model.sv */
`timescale 1ns/100ps

// ==================================================================
// Bus master model: drives the clock and pulls the data wire low.
// ==================================================================
module smbt_host_model (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // A quarter of the 125 ns link period.
  localparam realtime Q = 31.25;

  // The clock rests high between frames, and the wire floats up.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // Data falls while the clock is high to open or reopen a frame.
  task automatic start();
    sda_pull = 1'b0;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b1;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // Data moves only a quarter period after the clock falls.
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    #Q;
    scl = 1'b1;
    #Q;
    r = sda;
    #Q;
    scl = 1'b0;
    #Q;
  endtask

  // Nine clocks a byte; the master always releases the ninth slot.
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(1'b1, ack);
  endtask

  // Data low while the clock is low, then rising under a high clock.
  task automatic stop();
    sda_pull = 1'b1;
    #Q;
    scl = 1'b1;
    #Q;
    sda_pull = 1'b0;
    #Q;
  endtask
endmodule // smbt_host_model

/* File: smbt_target_sva.sv */
`timescale 1ns/100ps

// ==================================================================
// Port checker for the serial target.
// ==================================================================
module smbt_target_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 2500000
) (
  input logic                   clk,
  input logic                   reset,
  input logic                   scl_pin,
  input logic                   sda_in,
  input logic                   sda_out,
  input logic                   sda_oe,
  input logic                   alert_mode,
  input logic                   alert_cond,
  input logic                   status_latched,
  input logic                   alert_out,
  input logic                   alert_oe,
  input logic [7:0]             reg_ptr,
  input logic                   reg_wr_stb,
  input smbt_pkg::smbt_reg_wr_t reg_wr,
  input logic [7:0]             alert_ctrl,
  input logic [6:0]             own_addr
);
  import smbt_pkg::*;
  logic        scl_d;
  logic        sda_d;
  logic [31:0] quiet_cnt;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Counts cycles with both lines still; saturates past the limit plus sync slack.
  always_ff @(posedge clk) begin
    scl_d <= scl_pin;
    sda_d <= sda_in;
    if (reset || scl_pin != scl_d || sda_in != sda_d) quiet_cnt <= '0;
    else if (quiet_cnt < TIMEOUT_CYCLES + 16) quiet_cnt <= quiet_cnt + 1;
  end

  a_out_low: assert property (sda_out == 1'b0 && alert_out == 1'b0)
    else $error("open drain output drives high");
  a_reset_vals: assert property (@(posedge clk) disable iff (1'b0)
    reset |=> reg_ptr == 8'h00 && alert_ctrl == 8'h01 && !sda_oe && !alert_oe)
    else $error("wrong value after reset");
  a_alert_rise: assert property (alert_mode && alert_cond |=> alert_oe)
    else $error("alert not raised");
  a_alert_hold: assert property (
    alert_oe && alert_mode && (alert_cond || status_latched) |=> alert_oe)
    else $error("alert released too early");
  a_mode_off: assert property (!alert_mode |=> !alert_oe)
    else $error("alert driven outside alert mode");
  a_own_stable: assert property (own_addr != 7'h00 |=> $stable(own_addr))
    else $error("captured address changed");
  a_stb_single: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe longer than one cycle");
  a_wr_at_ptr: assert property (
    reg_wr_stb |-> reg_wr.addr == reg_ptr && reg_wr.addr != 8'h22)
    else $error("write not at pointer");
  a_oe_clk_low: assert property (!$stable(sda_oe) |-> !scl_pin)
    else $error("data drive changed while clock high");
  a_tout_release: assert property (
    alert_ctrl[7] && quiet_cnt == TIMEOUT_CYCLES + 16 |-> !sda_oe)
    else $error("bus held after timeout");
endmodule // smbt_target_chk

bind smbt_target smbt_target_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .scl_pin(scl_pin), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .alert_mode(alert_mode),
  .alert_cond(alert_cond), .status_latched(status_latched),
  .alert_out(alert_out), .alert_oe(alert_oe), .reg_ptr(reg_ptr),
  .reg_wr_stb(reg_wr_stb), .reg_wr(reg_wr), .alert_ctrl(alert_ctrl),
  .own_addr(own_addr));

/* File: smbt_target_tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

// ==================================================================
// Bench for the serial target.
// ==================================================================
module smbt_target_tb;
  import smbt_pkg::*;
  localparam int unsigned TOUT = 2000;
  logic         clk = 1'b0;
  logic         reset = 1'b1;
  logic         scl, pull, sda_oe, sda_out, alert_oe, alert_out, reg_wr_stb, ack;
  logic         alert_mode = 1'b0;
  logic         alert_cond = 1'b0;
  logic         status_latched = 1'b0;
  logic [7:0]   reg_ptr, alert_ctrl, rd;
  logic [6:0]   own_addr;
  smbt_reg_wr_t reg_wr, wr_seen;
  smbt_strap_t  sa = SMBT_STRAP_HIGH;
  smbt_strap_t  sb = SMBT_STRAP_HIGH;
  smbt_strap_t  st [3] = '{SMBT_STRAP_LOW, SMBT_STRAP_FLOAT, SMBT_STRAP_HIGH};
  logic [6:0]   ex [3] = '{7'h18, 7'h2A, 7'h4E};
  int           n_fail = 0;
  int           tests_run = 0;
  int           n_wr = 0;

  // Pull-up wire; the register file answers with a pattern of the pointer.
  wire       sda = !(pull || sda_oe);
  wire [7:0] reg_rdata = reg_ptr ^ 8'h5A;

  always #5 clk = ~clk;

  // Record every register write the block hands out.
  always @(posedge clk) begin
    if (reg_wr_stb === 1'b1) begin
      wr_seen <= reg_wr;
      n_wr <= n_wr + 1;
    end
  end

  smbt_target #(.TIMEOUT_CYCLES(TOUT)) dut (
    .clk(clk), .reset(reset), .scl_pin(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_a(sa), .addr_strap_b(sb), .alert_mode(alert_mode),
    .alert_cond(alert_cond), .status_latched(status_latched), .alert_out(alert_out),
    .alert_oe(alert_oe), .reg_rdata(reg_rdata), .reg_ptr(reg_ptr),
    .reg_wr_stb(reg_wr_stb), .reg_wr(reg_wr), .alert_ctrl(alert_ctrl),
    .own_addr(own_addr));

  smbt_host_model host (.scl(scl), .sda_pull(pull), .sda(sda));

  // ================================================================
  // Shared tasks.
  // ================================================================
  task automatic do_reset(input smbt_strap_t s);
    @(posedge clk);
    #1;
    sa = s;
    sb = s;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    reset = 1'b0;
    repeat (20) @(posedge clk);
    #1;
  endtask

  task automatic setal(input logic m, c, s);
    @(posedge clk);
    #1;
    alert_mode = m;
    alert_cond = c;
    status_latched = s;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // Write with n bytes after the address; only two are accepted.
  task automatic wr(input logic [6:0] a, input logic [7:0] p, d, input int n,
                    input logic ea);
    host.start();
    host.xfer({a, 1'b0}, rd, ack);
    `CHK(ack, ea)
    for (int k = 0; k < n; k++) begin
      host.xfer(k == 0 ? p : d, rd, ack);
      `CHK(ack, k > 1)
    end
    host.stop();
  endtask

  task automatic rdb(input logic [6:0] a, input logic ea, input logic [7:0] ed);
    host.start();
    host.xfer({a, 1'b1}, rd, ack);
    `CHK(ack, ea)
    host.xfer(8'hFF, rd, ack);
    `CHK(rd, ed)
    host.stop();
  endtask

  // Stall a read with the data bit driven low, then finish it.
  task automatic stall(input logic eo, input logic [7:0] ed);
    host.start();
    host.xfer({7'h4E, 1'b1}, rd, ack);
    repeat (TOUT + 500) @(posedge clk);
    `CHK(sda_oe, eo)
    host.xfer(8'hFF, rd, ack);
    `CHK(rd, ed)
    host.stop();
  endtask

  // ================================================================
  // Scenarios.
  // ================================================================
  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      do_reset(st[i]);
      `CHK(own_addr, ex[i])
      `CHK(alert_ctrl, 8'h01)
      sa = st[(i + 1) % 3];
      repeat (10) @(posedge clk);
      `CHK(own_addr, ex[i])
    end
  endtask

  task automatic t_write();
    wr(7'h4E, 8'h05, 8'hA5, 2, 1'b0);
    `CHK(reg_ptr, 8'h05)
    `CHK(wr_seen, 16'h05A5)
    wr(7'h4E, 8'h06, 8'h11, 3, 1'b0);
    `CHK(wr_seen, 16'h0611)
    `CHK(n_wr, 2)
  endtask

  task automatic t_read();
    wr(7'h4E, 8'h07, 8'h00, 1, 1'b0);
    `CHK(n_wr, 2)
    rdb(7'h4E, 1'b0, 8'h5D);
    wr(7'h4E, 8'h22, 8'h00, 1, 1'b0);
    rdb(7'h4E, 1'b0, 8'h01);
    wr(7'h30, 8'h00, 8'h00, 0, 1'b1);
    rdb(7'h0C, 1'b1, 8'hFF);
  endtask

  task automatic t_alert();
    setal(1'b1, 1'b1, 1'b1);
    `CHK(alert_oe, 1'b1)
    setal(1'b1, 1'b0, 1'b1);
    rdb(7'h0C, 1'b0, 8'h9D);
    `CHK(alert_oe, 1'b1)
    setal(1'b1, 1'b0, 1'b0);
    host.start();
    host.xfer(8'h19, rd, ack);
    host.xfer(8'h00, rd, ack);
    host.stop();
    `CHK(alert_oe, 1'b1)
    rdb(7'h0C, 1'b0, 8'h9D);
    `CHK(alert_oe, 1'b0)
    rdb(7'h0C, 1'b1, 8'hFF);
    setal(1'b1, 1'b1, 1'b0);
    setal(1'b0, 1'b1, 1'b0);
    `CHK(alert_oe, 1'b0)
    setal(1'b0, 1'b0, 1'b0);
  endtask

  task automatic t_timeout();
    wr(7'h4E, 8'h07, 8'h00, 1, 1'b0);
    stall(1'b1, 8'h5D);
    wr(7'h4E, 8'h22, 8'h81, 2, 1'b0);
    `CHK(alert_ctrl, 8'h81)
    wr(7'h4E, 8'h07, 8'h00, 1, 1'b0);
    stall(1'b0, 8'hFF);
    rdb(7'h4E, 1'b0, 8'h5D);
  endtask

  // ================================================================
  // Verdict and run control.
  // ================================================================
  task automatic results();
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // The whole run needs well under half a millisecond.
  initial begin
    #500000;
    n_fail++;
    results();
  end

  initial begin
    t_reset();
    t_write();
    t_read();
    t_alert();
    t_timeout();
    results();
  end
endmodule // smbt_target_tb
